//--- rtl/bfs_consts.svh
`ifndef BFS_CONSTS_SVH
`define BFS_CONSTS_SVH
// ----------------------------------------
// Clock and timing.
// ----------------------------------------
`define BFS_CLK_MHZ 250
`define BFS_OSC_DIV 125
`define BFS_BLANK_NS 80
`define BFS_BLANK_CYC ((`BFS_BLANK_NS * `BFS_CLK_MHZ + 999) / 1000)
`define BFS_DEAD_NS 20
`define BFS_DEAD_CYC ((`BFS_DEAD_NS * `BFS_CLK_MHZ + 999) / 1000)
`define BFS_EN_LOW_MAX 32
`define BFS_HIC_LIMIT 7
`define BFS_CNT_W 4
// ----------------------------------------
// Register offsets.
// ----------------------------------------
`define BFS_OFS_CTRL 4'h0
`define BFS_OFS_STATUS 4'h1
`define BFS_OFS_COUNT 4'h2
`define BFS_OFS_EVENTS 4'h3
// ----------------------------------------
// Field positions and reset values.
// ----------------------------------------
`define BFS_CTRL_EN 0
`define BFS_CTRL_ARM 1
`define BFS_CTRL_EN_RST 1'b1
`define BFS_CTRL_ARM_RST 1'b1
`define BFS_ST_STATE_LO 0
`define BFS_ST_STATE_HI 1
`define BFS_ST_ARMED 2
`define BFS_ST_OV 3
`define BFS_ST_UV 4
`define BFS_ST_OFF 5
`define BFS_ST_PG 6
`define BFS_ST_HS 7
`define BFS_EV_THERM 0
`define BFS_EV_OV 1
`define BFS_EV_OC 2
`define BFS_EV_HIC 3
`define BFS_EV_INPUT_UNDERVOLTAGE_LOCK 4
`define BFS_EV_W 5
`endif

//--- rtl/bfs_pkg.sv
package bfs_pkg;
  // ----------------------------------------
  // Shared types.
  // ----------------------------------------
  typedef enum logic [1:0] {BFS_OFF, BFS_START, BFS_RUN, BFS_HICCUP} bfs_state_t;
  typedef logic [3:0] bfs_addr_t;
  typedef logic [7:0] bfs_data_t;
endpackage : bfs_pkg

//--- rtl/bfs_top.sv
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`include "bfs_consts.svh"
// Notes on behaviour
// - Input undervoltage keeps the regulator off with both switches open.
// - Thermal trip discharges soft-start and compensation and opens both switches.
// - When the thermal trip clears, restart through normal soft-start automatically.
// - Overvoltage drops power good and stops switching.
// - Overvoltage leaves soft-start and compensation alone; recovery resumes everything.
// - Current over limit opens the high side for the rest of the cycle.
// - After a current cut, normal switching resumes at the next oscillator tick.
// - Current indication is ignored during blanking after each high-side turn-on.
// - Retry arms below the arm level, disarms above disarm level, else holds.
// - Counter steps up per cycle with overcurrent, down per cycle without.
// - Armed and count above seven sets the retry latch and stops switching.
// - While the retry latch is set, compensation is pulled low.
// - While the retry latch is set, the soft-start sink is enabled.
// - Soft-start below reset level clears the latch and turns the sink off.
// - After the latch clears, the soft-start charging source is enabled.
// - Switching resumes only once soft-start exceeds its offset level.
// - Retry cycles repeat while overload persists, until removed or disabled.
// - Dropout, long enable low or thermal trip: discharge, hold compensation low.
// - Under overvoltage the low side is off while compensation is below threshold.
// - Undervoltage drops power good while switching continues under loop control.
// - Cycle latch is set per cycle, reset by comparator, reset dominant.
// - Lockout, thermal trip, retry or disable opens both switches, leaving the switch node floating.
module bfs_top #(
  parameter int OSC_DIV = `BFS_OSC_DIV,
  parameter int EN_LOW_MAX = `BFS_EN_LOW_MAX,
  parameter int HIC_LIMIT = `BFS_HIC_LIMIT,
  parameter int BLANK_CYC = `BFS_BLANK_CYC,
  parameter int DEAD_CYC = `BFS_DEAD_CYC,
  parameter int CNT_W = `BFS_CNT_W
) (
  input wire logic CLK, // System clock.
  input wire logic RSTN, // Asynchronous reset, active low.
  input wire logic ENABLE_PIN, // Enable level from the pin.
  input wire logic INPUT_UNDERVOLTAGE_LOCK, // Supply below lockout.
  input wire logic THERMAL_TRIP, // Junction too hot, with hysteresis.
  input wire logic OVERVOLTAGE_GUARD, // Feedback above upper window.
  input wire logic FEEDBACK_UNDER, // Feedback below lower window.
  input wire logic CYCLE_CURRENT_GUARD, // High-side current over limit.
  input wire logic RETRY_ARM_LEVEL, // Feedback below arm level.
  input wire logic RETRY_DISARM_LEVEL, // Feedback above disarm level.
  input wire logic SOFTSTART_RESET_LEVEL, // Soft-start below reset level.
  input wire logic SOFTSTART_OFFSET_LEVEL, // Soft-start above offset level.
  input wire logic COMP_LOW_LEVEL, // Compensation below threshold.
  input wire logic PWM_COMPARE_RESET, // Comparator ends the on-time.
  input wire bfs_pkg::bfs_addr_t ADDR, // Register index.
  input wire bfs_pkg::bfs_data_t WDATA, // Write data.
  input wire logic WR, // Write strobe.
  input wire logic RD, // Read strobe.
  output logic [7:0] RDATA, // Read data, one cycle after RD.
  output logic HS_GATE_EN, // High-side switch on.
  output logic LS_GATE_EN, // Low-side switch on.
  output logic POWER_GOOD_OUT, // Power good, high when in range.
  output logic SS_DISCHARGE, // Fast soft-start pulldown.
  output logic SS_SINK_EN, // Small soft-start current sink.
  output logic SS_SOURCE_EN, // Soft-start charging source.
  output logic COMP_PULL_LOW // Compensation node clamp.
);
  import bfs_pkg::*;

  localparam int OW = $clog2(OSC_DIV + 1);
  localparam int EW = $clog2(EN_LOW_MAX + 2);
  localparam int BW = $clog2(BLANK_CYC + 2);
  localparam int DW = $clog2(DEAD_CYC + 2);

  // Register index match, shared by the read and write paths.
  function automatic logic reg_hit(input bfs_addr_t a, input bfs_addr_t ofs);
    reg_hit = (a == ofs);
  endfunction : reg_hit

  // ----------------------------------------
  // Oscillator divider.
  // ----------------------------------------

  logic [OW-1:0] osc_cnt_ff;
  logic [OW-1:0] nxt_osc_cnt;
  logic tick_ff;
  wire osc_wrap = (osc_cnt_ff == OW'(OSC_DIV - 1));

  // The tick marks the start of each switching cycle.
  assign nxt_osc_cnt = osc_wrap ? '0 : osc_cnt_ff + 1'b1;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      osc_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      osc_cnt_ff <= nxt_osc_cnt;
      tick_ff <= osc_wrap;
    end
  end

  // ----------------------------------------
  // Registers written by software.
  // ----------------------------------------

  logic ctl_en_ff;
  logic ctl_arm_ff;
  logic [`BFS_EV_W-1:0] ev_ff;
  logic [`BFS_EV_W-1:0] nxt_ev;
  logic [`BFS_EV_W-1:0] ev_set;
  wire wr_ctrl = WR && reg_hit(ADDR, `BFS_OFS_CTRL);
  wire wr_ev = WR && reg_hit(ADDR, `BFS_OFS_EVENTS);
  wire [`BFS_EV_W-1:0] ev_clr = wr_ev ? WDATA[`BFS_EV_W-1:0] : '0;

  // Write one to clear; a new event in the same cycle wins over the clear.
  assign nxt_ev = (ev_ff & ~ev_clr) | ev_set;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctl_en_ff <= `BFS_CTRL_EN_RST;
      ctl_arm_ff <= `BFS_CTRL_ARM_RST;
      ev_ff <= '0;
    end else begin
      if (wr_ctrl) begin
        ctl_en_ff <= WDATA[`BFS_CTRL_EN];
        ctl_arm_ff <= WDATA[`BFS_CTRL_ARM];
      end
      ev_ff <= nxt_ev;
    end
  end

  // ----------------------------------------
  // Enable filter.
  // ----------------------------------------

  // Short low pulses on the pin are tolerated; only a low held past the
  // limit counts as a disable, so a sync clock on the pin never stops us.
  logic [EW-1:0] en_low_ff;
  logic [EW-1:0] nxt_en_low;
  wire pin_off = (en_low_ff > EW'(EN_LOW_MAX));
  wire disabled = pin_off || !ctl_en_ff;
  wire shut = INPUT_UNDERVOLTAGE_LOCK || THERMAL_TRIP || disabled;

  assign nxt_en_low = ENABLE_PIN ? '0 :
                      (tick_ff && !pin_off) ? en_low_ff + 1'b1 : en_low_ff;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      en_low_ff <= '0;
    end else begin
      en_low_ff <= nxt_en_low;
    end
  end

  // ----------------------------------------
  // Retry arming.
  // ----------------------------------------

  // Arm wins if both levels are reported at once, the safer reading.
  logic armed_ff;
  logic nxt_armed;
  wire armed = armed_ff && ctl_arm_ff;

  assign nxt_armed = RETRY_ARM_LEVEL ? 1'b1 :
                     RETRY_DISARM_LEVEL ? 1'b0 : armed_ff;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      armed_ff <= 1'b1;
    end else begin
      armed_ff <= nxt_armed;
    end
  end

  // ----------------------------------------
  // Fault sequencer.
  // ----------------------------------------

  bfs_state_t state_ff;
  bfs_state_t nxt_state;
  logic hic_set;

  // Off discharges, start charges with the clamp held, run switches,
  // hiccup sinks soft-start down before trying again.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      BFS_OFF: begin
        if (!shut && SOFTSTART_RESET_LEVEL) begin
          nxt_state = BFS_START;
        end
      end
      BFS_START: begin
        if (shut) begin
          nxt_state = BFS_OFF;
        end else if (SOFTSTART_OFFSET_LEVEL) begin
          nxt_state = BFS_RUN;
        end
      end
      BFS_RUN: begin
        if (shut) begin
          nxt_state = BFS_OFF;
        end else if (hic_set) begin
          nxt_state = BFS_HICCUP;
        end
      end
      BFS_HICCUP: begin
        if (shut) begin
          nxt_state = BFS_OFF;
        end else if (SOFTSTART_RESET_LEVEL) begin
          nxt_state = BFS_START;
        end
      end
      default: begin
        nxt_state = BFS_OFF;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_ff <= BFS_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // Cycle latch and current limit.
  // ----------------------------------------

  logic pwm_latch_ff;
  logic cut_ff;
  logic seen_ff;
  logic hs_ff;
  logic ls_ff;
  logic [BW-1:0] blank_ff;
  logic [BW-1:0] nxt_blank;
  logic [DW-1:0] dead_ff;
  logic [DW-1:0] nxt_dead;
  logic nxt_latch;
  logic nxt_cut;
  logic nxt_seen;
  logic nxt_hs;
  logic nxt_ls;
  wire run_live = (state_ff == BFS_RUN) && !shut;
  wire in_run = run_live && !hic_set;
  wire blank_done = (blank_ff == '0);
  wire oc_hit = hs_ff && blank_done && CYCLE_CURRENT_GUARD;
  wire cycle_oc = seen_ff || oc_hit;

  // Reset dominant, so a comparator held high skips the pulse entirely.
  assign nxt_latch = PWM_COMPARE_RESET ? 1'b0 :
                     tick_ff ? 1'b1 : pwm_latch_ff;

  // The cut stands until the next tick opens a fresh cycle.
  assign nxt_cut = tick_ff ? 1'b0 : (cut_ff || oc_hit);
  assign nxt_seen = tick_ff ? 1'b0 : (seen_ff || oc_hit);

  // Overvoltage only gates the switches; the analog nodes are untouched.
  wire hs_want = in_run && pwm_latch_ff && !cut_ff && !OVERVOLTAGE_GUARD;
  assign nxt_hs = hs_want && !ls_ff && !oc_hit;

  // Low side waits out the dead time after the high side opens.
  wire ls_block = OVERVOLTAGE_GUARD && COMP_LOW_LEVEL;
  assign nxt_ls = in_run && !hs_want && !hs_ff && (dead_ff == '0) && !ls_block;

  // Blanking restarts at every high-side turn-on.
  assign nxt_blank = (nxt_hs && !hs_ff) ? BW'(BLANK_CYC) :
                     blank_done ? blank_ff : blank_ff - 1'b1;
  assign nxt_dead = (hs_ff && !nxt_hs) ? DW'(DEAD_CYC) :
                    (dead_ff == '0) ? dead_ff : dead_ff - 1'b1;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pwm_latch_ff <= 1'b0;
      cut_ff <= 1'b0;
      seen_ff <= 1'b0;
      blank_ff <= '0;
      dead_ff <= '0;
    end else begin
      pwm_latch_ff <= nxt_latch;
      cut_ff <= nxt_cut;
      seen_ff <= nxt_seen;
      blank_ff <= nxt_blank;
      dead_ff <= nxt_dead;
    end
  end

  // ----------------------------------------
  // Overload counter.
  // ----------------------------------------

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  wire cnt_full = (cnt_ff == {CNT_W{1'b1}});
  wire cnt_zero = (cnt_ff == '0);
  wire cnt_step = tick_ff && run_live;

  // The latch sets when this cycle's overcurrent would carry the count past the limit.
  assign hic_set = cnt_step && cycle_oc && armed && (cnt_ff >= CNT_W'(HIC_LIMIT));

  always_comb begin
    nxt_cnt = cnt_ff;
    if (shut || hic_set) begin
      nxt_cnt = '0;
    end else if (cnt_step && cycle_oc && !cnt_full) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (cnt_step && !cycle_oc && !cnt_zero) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // ----------------------------------------
  // Output stage.
  // ----------------------------------------

  // Power good and the soft-start and clamp outputs follow the next state, so they move on the same edge as the state.
  wire go_off = (nxt_state == BFS_OFF);
  wire go_hic = (nxt_state == BFS_HICCUP);
  wire go_run = (nxt_state == BFS_RUN);
  wire nxt_pg = go_run && !shut && !FEEDBACK_UNDER && !OVERVOLTAGE_GUARD;
  wire nxt_comp = !go_run;
  wire nxt_src = (nxt_state == BFS_START) || go_run;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      hs_ff <= 1'b0;
      ls_ff <= 1'b0;
      POWER_GOOD_OUT <= 1'b0;
      SS_DISCHARGE <= 1'b1;
      SS_SINK_EN <= 1'b0;
      SS_SOURCE_EN <= 1'b0;
      COMP_PULL_LOW <= 1'b1;
    end else begin
      hs_ff <= nxt_hs;
      ls_ff <= nxt_ls;
      POWER_GOOD_OUT <= nxt_pg;
      SS_DISCHARGE <= go_off;
      SS_SINK_EN <= go_hic;
      SS_SOURCE_EN <= nxt_src;
      COMP_PULL_LOW <= nxt_comp;
    end
  end

  assign HS_GATE_EN = hs_ff;
  assign LS_GATE_EN = ls_ff;

  // ----------------------------------------
  // Events and read path.
  // ----------------------------------------

  // Events are level sticky: a fault still present sets its bit again.
  assign ev_set[`BFS_EV_THERM] = THERMAL_TRIP;
  assign ev_set[`BFS_EV_OV] = OVERVOLTAGE_GUARD;
  assign ev_set[`BFS_EV_OC] = oc_hit;
  assign ev_set[`BFS_EV_HIC] = hic_set;
  assign ev_set[`BFS_EV_INPUT_UNDERVOLTAGE_LOCK] = INPUT_UNDERVOLTAGE_LOCK;

  logic [7:0] status_w;
  logic [7:0] ctrl_w;
  logic [7:0] rd_mux;

  assign status_w[`BFS_ST_STATE_HI:`BFS_ST_STATE_LO] = state_ff;
  assign status_w[`BFS_ST_ARMED] = armed;
  assign status_w[`BFS_ST_OV] = OVERVOLTAGE_GUARD;
  assign status_w[`BFS_ST_UV] = FEEDBACK_UNDER;
  assign status_w[`BFS_ST_OFF] = disabled;
  assign status_w[`BFS_ST_PG] = POWER_GOOD_OUT;
  assign status_w[`BFS_ST_HS] = hs_ff;

  always_comb begin
    ctrl_w = '0;
    ctrl_w[`BFS_CTRL_EN] = ctl_en_ff;
    ctrl_w[`BFS_CTRL_ARM] = ctl_arm_ff;
  end

  // Unmapped indices read as zero.
  assign rd_mux = reg_hit(ADDR, `BFS_OFS_CTRL) ? ctrl_w :
                  reg_hit(ADDR, `BFS_OFS_STATUS) ? status_w :
                  reg_hit(ADDR, `BFS_OFS_COUNT) ? 8'(cnt_ff) :
                  reg_hit(ADDR, `BFS_OFS_EVENTS) ? 8'(ev_ff) : 8'h00;

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= RD ? rd_mux : 8'h00;
    end
  end

endmodule : bfs_top

//--- dv/bfs_properties.sv
`timescale 1ns/1ns
// ----------------------------------------
// Port-level checks of the fault sequencer.
// ----------------------------------------
module bfs_checker #(
  parameter int BLANK_CYC = 20
) (
  input wire logic CLK, // Clock.
  input wire logic RSTN, // Reset.
  input wire logic ENABLE_PIN, // Enable.
  input wire logic INPUT_UNDERVOLTAGE_LOCK, // Lockout.
  input wire logic THERMAL_TRIP, // Hot.
  input wire logic OVERVOLTAGE_GUARD, // Over window.
  input wire logic FEEDBACK_UNDER, // Under window.
  input wire logic CYCLE_CURRENT_GUARD, // Overcurrent.
  input wire logic SOFTSTART_RESET_LEVEL, // Soft-start low.
  input wire logic COMP_LOW_LEVEL, // Comp low.
  input wire logic PWM_COMPARE_RESET, // On-time end.
  input wire logic HS_GATE_EN, // High side.
  input wire logic LS_GATE_EN, // Low side.
  input wire logic POWER_GOOD_OUT, // Power good.
  input wire logic SS_DISCHARGE, // Discharge.
  input wire logic SS_SINK_EN, // Sink.
  input wire logic SS_SOURCE_EN, // Source.
  input wire logic COMP_PULL_LOW // Clamp.
);
  logic [7:0] hs_cnt_ff;
  logic [7:0] nxt_hs_cnt;
  logic calm;
  // High-side on-time count; it saturates so a long pulse never wraps back into blanking.
  assign nxt_hs_cnt = !HS_GATE_EN ? 8'h00 : (hs_cnt_ff == 8'hff ? hs_cnt_ff : hs_cnt_ff + 8'h01);
  assign calm = ENABLE_PIN && !INPUT_UNDERVOLTAGE_LOCK && !THERMAL_TRIP;
  // On-time counter register.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      hs_cnt_ff <= 8'h00;
    end else begin
      hs_cnt_ff <= nxt_hs_cnt;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  AST_INPUT_UNDERVOLTAGE_LOCK_OFF: assert property (INPUT_UNDERVOLTAGE_LOCK |=> !HS_GATE_EN && !LS_GATE_EN && !POWER_GOOD_OUT)
    else $error("switching under lockout");
  AST_THERM_CLAMP: assert property (THERMAL_TRIP |=> SS_DISCHARGE && COMP_PULL_LOW && !HS_GATE_EN && !LS_GATE_EN)
    else $error("thermal trip not clamped");
  AST_OV_STOP: assert property (OVERVOLTAGE_GUARD |=> !POWER_GOOD_OUT && !HS_GATE_EN)
    else $error("overvoltage kept switching");
  AST_OV_KEEP_SS: assert property (OVERVOLTAGE_GUARD && calm && !SS_DISCHARGE |=> !SS_DISCHARGE)
    else $error("overvoltage discharged soft-start");
  AST_OV_LS: assert property (OVERVOLTAGE_GUARD && COMP_LOW_LEVEL |=> !LS_GATE_EN)
    else $error("low side on with comp low");
  AST_OC_CUT: assert property (HS_GATE_EN && CYCLE_CURRENT_GUARD && hs_cnt_ff > BLANK_CYC |=> !HS_GATE_EN)
    else $error("high side not cut");
  AST_BLANK: assert property (HS_GATE_EN && hs_cnt_ff == 8'h00 && CYCLE_CURRENT_GUARD && calm && !OVERVOLTAGE_GUARD
    && !PWM_COMPARE_RESET && !$past(PWM_COMPARE_RESET) |=> HS_GATE_EN)
    else $error("current cut inside blanking");
  AST_UV_PG: assert property (FEEDBACK_UNDER |=> !POWER_GOOD_OUT)
    else $error("power good under undervoltage");
  AST_HIC_CLAMP: assert property (SS_SINK_EN |-> COMP_PULL_LOW && !HS_GATE_EN && !SS_SOURCE_EN)
    else $error("retry outputs wrong");
  AST_HIC_EXIT: assert property (SS_SINK_EN && SOFTSTART_RESET_LEVEL && calm |=> !SS_SINK_EN && SS_SOURCE_EN)
    else $error("retry latch not cleared");
  AST_CLAMP_NO_SW: assert property (COMP_PULL_LOW || SS_DISCHARGE |-> !HS_GATE_EN && !LS_GATE_EN)
    else $error("switching while clamped");
  AST_DISCH_HOLD: assert property (SS_DISCHARGE && !SOFTSTART_RESET_LEVEL |=> SS_DISCHARGE)
    else $error("discharge released early");
endmodule : bfs_checker

bind bfs_top bfs_checker #(.BLANK_CYC(BLANK_CYC)) i_chk (.*);

//--- dv/bfs_stage_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Analog stage stand-in.
// ----------------------------------------
module bfs_stage_model (
  input wire logic CLK, // Clock.
  input wire logic SS_DISCHARGE, // Fast pulldown.
  input wire logic SS_SINK_EN, // Slow sink.
  input wire logic SS_SOURCE_EN, // Charging source.
  input wire logic COMP_PULL_LOW, // Comp clamp.
  input wire logic OVERVOLTAGE_GUARD, // Over window.
  input wire logic HS_GATE_EN, // High side on.
  input wire logic [3:0] ON_LEN, // On-time in cycles.
  output logic SOFTSTART_RESET_LEVEL, // Below reset level.
  output logic SOFTSTART_OFFSET_LEVEL, // Above offset level.
  output logic COMP_LOW_LEVEL, // Comp below threshold.
  output logic PWM_COMPARE_RESET // End of on-time.
);
  int ss = 0;
  int on_t = 0;
  // Soft-start as a coarse integer; the sink is slow so a retry spans several ticks.
  always @(posedge CLK) begin
    if (SS_DISCHARGE) begin
      ss <= (ss < 4) ? 0 : ss - 4;
    end else if (SS_SINK_EN) begin
      ss <= (ss < 1) ? 0 : ss - 1;
    end else if (SS_SOURCE_EN) begin
      ss <= (ss > 39) ? 40 : ss + 1;
    end
    on_t <= HS_GATE_EN ? on_t + 1 : 0;
  end
  // Level comparators; the loop drags comp low during overvoltage.
  assign SOFTSTART_RESET_LEVEL = ss < 3;
  assign SOFTSTART_OFFSET_LEVEL = ss > 10;
  assign COMP_LOW_LEVEL = COMP_PULL_LOW || OVERVOLTAGE_GUARD;
  assign PWM_COMPARE_RESET = HS_GATE_EN && on_t >= int'(ON_LEN);
endmodule : bfs_stage_model

//--- dv/bfs_top_bench.sv
`timescale 1ns/1ns
module bfs_top_bench;
  import bfs_pkg::*;
  localparam int DIV = 8;
  localparam int HS = 7;
  localparam int LS = 6;
  localparam int PG = 5;
  localparam int DIS = 4;
  localparam int SNK = 3;
  localparam int SRC = 2;
  localparam int CMP = 1;
  logic CLK = 1'b0, RSTN = 1'b0, ENABLE_PIN = 1'b1, INPUT_UNDERVOLTAGE_LOCK = 1'b0, THERMAL_TRIP = 1'b0;
  logic OVERVOLTAGE_GUARD = 1'b0, FEEDBACK_UNDER = 1'b0, CYCLE_CURRENT_GUARD = 1'b0;
  logic RETRY_ARM_LEVEL = 1'b0, RETRY_DISARM_LEVEL = 1'b1, WR = 1'b0, RD = 1'b0;
  bfs_addr_t ADDR = 4'h0;
  bfs_data_t WDATA = 8'h00;
  logic [3:0] ON_LEN = 4'h3;
  logic [7:0] RDATA;
  wire HS_GATE_EN, LS_GATE_EN, POWER_GOOD_OUT, SS_DISCHARGE, SS_SINK_EN, SS_SOURCE_EN, COMP_PULL_LOW;
  wire SOFTSTART_RESET_LEVEL, SOFTSTART_OFFSET_LEVEL, COMP_LOW_LEVEL, PWM_COMPARE_RESET;
  wire [7:0] obs = {HS_GATE_EN, LS_GATE_EN, POWER_GOOD_OUT, SS_DISCHARGE, SS_SINK_EN, SS_SOURCE_EN, COMP_PULL_LOW, 1'b0};
  int seed = 9826;
  int bad_count = 0;
  int checks = 0;
  // Clock toggles every half period.
  always #2 CLK = ~CLK;
  bfs_top #(.OSC_DIV(DIV), .EN_LOW_MAX(2), .BLANK_CYC(2), .DEAD_CYC(1)) i_dut (.*);
  bfs_stage_model i_stage (.*);
  // ----------------------------------------
  // Helpers.
  // ----------------------------------------
  function automatic logic [7:0] cnt_exp(input int n);
    return (n > 15) ? 8'h0f : n[7:0];
  endfunction : cnt_exp
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Bounded wait for an output level, so a stuck design cannot hang the run.
  task automatic wt(input string n, input int b, input logic v, input int lim);
    for (int i = 0; i < lim && obs[b] !== v; i++) @(posedge CLK);
    chk(n, {7'h00, v}, {7'h00, obs[b]});
  endtask : wt
  task automatic nev(input string n, input int b, input int len);
    logic s;
    s = 1'b0;
    repeat (len) begin
      @(posedge CLK);
      s = s | obs[b];
    end
    chk(n, 8'h00, {7'h00, s});
  endtask : nev
  task automatic wr(input bfs_addr_t a, input bfs_data_t d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input string n, input bfs_addr_t a, input bfs_data_t e);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    @(negedge CLK);
    chk(n, e, RDATA);
  endtask : rd
  task automatic complete_run;
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  // Watchdog well beyond the expected run length.
  initial begin
    #200000;
    bad_count++;
    complete_run();
  end
  // ----------------------------------------
  // Scenarios.
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge CLK);
    chk("reset outputs", 8'h12, obs);
    RSTN <= 1'b1;
    rd("ctrl reset", 4'h0, 8'h03);
    rd("unmapped", 4'hf, 8'h00);
    wt("start", HS, 1'b1, 300);
    wt("pg up", PG, 1'b1, 30);
    $display("test startup done");
    @(posedge CLK) FEEDBACK_UNDER <= 1'b1;
    @(posedge CLK);
    nev("uv pg", PG, DIV);
    wt("uv switching", HS, 1'b1, 3 * DIV);
    @(posedge CLK) FEEDBACK_UNDER <= 1'b0;
    wt("uv recover", PG, 1'b1, 4);
    @(posedge CLK) OVERVOLTAGE_GUARD <= 1'b1;
    @(posedge CLK);
    nev("ov hs", HS, 3 * DIV);
    nev("ov ls", LS, DIV);
    nev("ov ss", DIS, DIV);
    @(posedge CLK) OVERVOLTAGE_GUARD <= 1'b0;
    wt("ov resume", HS, 1'b1, 3 * DIV);
    wt("ov pg", PG, 1'b1, 3 * DIV);
    $display("test window done");
    wr(4'h3, 8'h1f);
    @(posedge CLK) THERMAL_TRIP <= 1'b1;
    wt("hot discharge", DIS, 1'b1, 4);
    rd("hot event", 4'h3, 8'h01);
    nev("hot hs", HS, 2 * DIV);
    @(posedge CLK) THERMAL_TRIP <= 1'b0;
    wt("hot restart", HS, 1'b1, 300);
    wr(4'h3, 8'h1f);
    rd("event clear", 4'h3, 8'h00);
    wr(4'h1, 8'h00);
    @(posedge CLK) INPUT_UNDERVOLTAGE_LOCK <= 1'b1;
    @(posedge CLK);
    nev("lock hs", HS, 3 * DIV);
    @(posedge CLK) INPUT_UNDERVOLTAGE_LOCK <= 1'b0;
    wt("lock restart", HS, 1'b1, 300);
    $display("test faults done");
    @(posedge CLK) ENABLE_PIN <= 1'b0;
    nev("short low", DIS, DIV);
    @(posedge CLK) ENABLE_PIN <= 1'b1;
    repeat (2 * DIV) @(posedge CLK);
    @(posedge CLK) ENABLE_PIN <= 1'b0;
    wt("long low", DIS, 1'b1, 5 * DIV);
    chk("long low pg", 8'h00, {7'h00, obs[PG]});
    @(posedge CLK) ENABLE_PIN <= 1'b1;
    wt("enable restart", HS, 1'b1, 300);
    $display("test enable done");
    @(posedge CLK) CYCLE_CURRENT_GUARD <= 1'b1;
    repeat (20 * DIV) @(posedge CLK);
    rd("count up", 4'h2, cnt_exp(20));
    wt("next tick", HS, 1'b1, 2 * DIV);
    @(posedge CLK) CYCLE_CURRENT_GUARD <= 1'b0;
    repeat (20 * DIV) @(posedge CLK);
    rd("count floor", 4'h2, 8'h00);
    @(posedge CLK) {RETRY_ARM_LEVEL, RETRY_DISARM_LEVEL, CYCLE_CURRENT_GUARD} <= 3'b101;
    wt("retry set", SNK, 1'b1, 12 * DIV);
    chk("retry comp", 8'h01, {7'h00, obs[CMP]});
    rd("count clear", 4'h2, 8'h00);
    wt("retry source", SRC, 1'b1, 100);
    @(posedge CLK) RETRY_ARM_LEVEL <= 1'b0;
    wt("retry again", SNK, 1'b1, 300);
    @(posedge CLK) CYCLE_CURRENT_GUARD <= 1'b0;
    wt("retry end", SNK, 1'b0, 100);
    wt("retry resume", HS, 1'b1, 300);
    @(posedge CLK) {RETRY_DISARM_LEVEL, CYCLE_CURRENT_GUARD} <= 2'b11;
    nev("disarmed", SNK, 14 * DIV);
    $display("test retry done");
    repeat (400) begin
      @(posedge CLK);
      {CYCLE_CURRENT_GUARD, FEEDBACK_UNDER} <= 2'($random(seed));
      ON_LEN <= 4'($random(seed)) | 4'h1;
    end
    @(posedge CLK) {CYCLE_CURRENT_GUARD, FEEDBACK_UNDER} <= 2'b00;
    wt("random pg", PG, 1'b1, 3 * DIV);
    $display("test random done");
    complete_run();
  end
endmodule : bfs_top_bench
